// >>> ccr_config_regs.v
// configuration register bank: soft reset, output interface, power down
// Behaviour
// - soft reset bit restores defaults, self clears
// - lane mapping codes decode to output variants
// - written mapping applies only after fuse load
// - fuse load discards earlier serial writes, but first applies a written mapping
// - fuse default interface applied after reset
// - mapping and select read zero until written
// - override enable lets select choose interface
// - select codes decode to interface modes
// - power down bits for clock, reference, channel
// - full power down bit, its own output, gates no other block
`timescale 1ns/1ns
`include "ccr_defines.vh"
module ccr_config_regs #(
   parameter [2:0] FUSE_MAP_DEFAULT = 3'h6
) (
   input wire core_clk,
   input wire resetn,
   input wire wr_en,
   input wire rd_en,
   input wire [11:0] addr,
   input wire [7:0] wr_data,
   output reg [7:0] rd_data,
   output wire [5:0] iface_mode,
   output wire iface_mode_valid,
   output wire clock_buffer_powerdown,
   output wire ref_amp_powerdown,
   output wire channel_powerdown,
   output wire full_powerdown
);
   // ==========================================
   // address and field helpers
   function reg_hit;
      input [11:0] a;
      input [11:0] off;
      begin
         reg_hit = (a == off);
      end
   endfunction

   function [7:0] iface_view;
      input [7:0] cfg;
      input map_seen;
      input sel_seen;
      begin
         iface_view = cfg & `CCR_IFACE_WMASK;
         if (!map_seen) begin
            iface_view[`CCR_MAP_HI:`CCR_MAP_LO] = 3'h0;
         end
         if (!sel_seen) begin
            iface_view[`CCR_SEL_HI:`CCR_SEL_LO] = 3'h0;
         end
      end
   endfunction

   function [7:0] pd_value;
      input [7:0] data;
      begin
         // reserved bits stored low, fixed bit stored high
         pd_value = data & `CCR_PD_WMASK;
         pd_value[`CCR_PD_FIXED_ONE_BIT] = 1'b1;
      end
   endfunction

   // ==========================================
   // state
   reg soft_reset_r;
   reg soft_reset_nxt;
   reg [7:0] iface_cfg_r;
   reg [7:0] iface_cfg_nxt;
   reg map_written_r;
   reg map_written_nxt;
   reg sel_written_r;
   reg sel_written_nxt;
   reg [7:0] pd_r;
   reg [7:0] pd_nxt;
   reg [2:0] active_map_r;
   reg [2:0] active_map_nxt;
   reg [7:0] rd_data_nxt;
   reg [5:0] mode_r;
   reg mode_valid_r;
   wire [5:0] mode_dec;
   wire mode_dec_valid;
   wire wr_soft;
   wire wr_iface;
   wire wr_pd;
   wire wr_fuse;
   wire clear_all;

   // ==========================================
   // write strobes
   assign wr_soft = wr_en && reg_hit(addr, `CCR_OFF_SOFT_RESET)
      && wr_data[`CCR_SOFT_RESET_BIT];
   assign wr_iface = wr_en && reg_hit(addr, `CCR_OFF_IFACE_CFG);
   assign wr_pd = wr_en && reg_hit(addr, `CCR_OFF_POWER_DOWN);
   assign wr_fuse = wr_en && reg_hit(addr, `CCR_OFF_FUSE_LOAD)
      && wr_data[`CCR_FUSE_LOAD_BIT];
   // both commands put the interface and power down registers back to their defaults
   assign clear_all = soft_reset_r || wr_fuse;

   // ==========================================
   // soft reset pulse
   always @* begin
      // one cycle pulse, nothing holds it
      soft_reset_nxt = wr_soft;
   end

   always @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         soft_reset_r <= 1'b0;
      end else begin
         soft_reset_r <= soft_reset_nxt;
      end
   end

   // ==========================================
   // output interface register
   always @* begin
      iface_cfg_nxt = iface_cfg_r;
      map_written_nxt = map_written_r;
      sel_written_nxt = sel_written_r;
      if (clear_all) begin
         iface_cfg_nxt = `CCR_IFACE_RESET;
         map_written_nxt = 1'b0;
         sel_written_nxt = 1'b0;
      end else if (wr_iface) begin
         // reserved bit always stored as zero
         iface_cfg_nxt = wr_data & `CCR_IFACE_WMASK;
         map_written_nxt = 1'b1;
         sel_written_nxt = 1'b1;
      end
   end

   always @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         iface_cfg_r <= `CCR_IFACE_RESET;
         map_written_r <= 1'b0;
         sel_written_r <= 1'b0;
      end else begin
         iface_cfg_r <= iface_cfg_nxt;
         map_written_r <= map_written_nxt;
         sel_written_r <= sel_written_nxt;
      end
   end

   // ==========================================
   // power down register
   always @* begin
      pd_nxt = pd_r;
      if (clear_all) begin
         pd_nxt = `CCR_PD_RESET;
      end else if (wr_pd) begin
         pd_nxt = pd_value(wr_data);
      end
   end

   always @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         pd_r <= `CCR_PD_RESET;
      end else begin
         pd_r <= pd_nxt;
      end
   end

   // ==========================================
   // fuse loaded lane mapping
   always @* begin
      active_map_nxt = active_map_r;
      if (wr_fuse) begin
         // written mapping goes live only here
         if (map_written_r) begin
            active_map_nxt = iface_cfg_r[`CCR_MAP_HI:`CCR_MAP_LO];
         end else begin
            active_map_nxt = FUSE_MAP_DEFAULT;
         end
      end else if (active_map_r == `CCR_MAP_EMPTY) begin
         // fuse default after reset, no command needed
         active_map_nxt = FUSE_MAP_DEFAULT;
      end
   end

   always @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         active_map_r <= `CCR_MAP_EMPTY;
      end else begin
         active_map_r <= active_map_nxt;
      end
   end

   // ==========================================
   // mode decode
   ccr_mode_decode u_decode (
      .map_code(active_map_r),
      .sel_code(iface_cfg_r[`CCR_SEL_HI:`CCR_SEL_LO]),
      .use_sel(iface_cfg_r[`CCR_OVR_EN_BIT]),
      .mode_onehot(mode_dec),
      .code_valid(mode_dec_valid)
   );

   // mode leaves through flops, one cycle behind the registers
   always @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         mode_r <= `CCR_MODE_NONE;
         mode_valid_r <= 1'b0;
      end else begin
         mode_r <= mode_dec;
         mode_valid_r <= mode_dec_valid;
      end
   end

   assign iface_mode = mode_r;
   assign iface_mode_valid = mode_valid_r;

   // ==========================================
   // power down outputs
   assign clock_buffer_powerdown = pd_r[`CCR_PD_CLKBUF_BIT];
   assign ref_amp_powerdown = pd_r[`CCR_PD_REFAMP_BIT];
   assign channel_powerdown = pd_r[`CCR_PD_CHAN_BIT];
   assign full_powerdown = pd_r[`CCR_PD_FULL_BIT];

   // ==========================================
   // readback
   always @* begin
      rd_data_nxt = rd_data;
      if (rd_en) begin
         if (reg_hit(addr, `CCR_OFF_IFACE_CFG)) begin
            rd_data_nxt = iface_view(iface_cfg_r, map_written_r,
               sel_written_r);
         end else if (reg_hit(addr, `CCR_OFF_POWER_DOWN)) begin
            rd_data_nxt = pd_r;
         end else begin
            // soft reset and all other addresses always read zero
            rd_data_nxt = 8'h00;
         end
      end
   end

   always @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         rd_data <= 8'h00;
      end else begin
         rd_data <= rd_data_nxt;
      end
   end
endmodule // ccr_config_regs

// >>> ccr_defines.vh
// constants for the converter configuration register bank
`ifndef CCR_DEFINES_VH
`define CCR_DEFINES_VH
`define CCR_ADDR_W 12
`define CCR_OFF_SOFT_RESET 12'h000
`define CCR_OFF_IFACE_CFG 12'h007
`define CCR_OFF_POWER_DOWN 12'h008
`define CCR_OFF_FUSE_LOAD 12'h013
`define CCR_SOFT_RESET_BIT 0
`define CCR_FUSE_LOAD_BIT 0
`define CCR_MAP_HI 7
`define CCR_MAP_LO 5
`define CCR_OVR_EN_BIT 3
`define CCR_SEL_HI 2
`define CCR_SEL_LO 0
`define CCR_PD_CLKBUF_BIT 5
`define CCR_PD_REFAMP_BIT 4
`define CCR_PD_CHAN_BIT 2
`define CCR_PD_FIXED_ONE_BIT 1
`define CCR_PD_FULL_BIT 0
`define CCR_IFACE_RESET 8'h00
`define CCR_PD_RESET 8'h02
`define CCR_PD_WMASK 8'h35
`define CCR_IFACE_WMASK 8'hEF
`define CCR_MAP_EMPTY 3'h0
`define CCR_MAP_2W_18_14 3'h1
`define CCR_MAP_2W_16 3'h2
`define CCR_MAP_1W 3'h3
`define CCR_MAP_HALF_W 3'h4
`define CCR_MAP_DDR 3'h5
`define CCR_MAP_SDR 3'h6
`define CCR_SEL_SDR 3'h0
`define CCR_SEL_DDR 3'h1
`define CCR_SEL_2W 3'h3
`define CCR_SEL_1W 3'h4
`define CCR_SEL_HALF_W 3'h5
`define CCR_MODE_W 6
`define CCR_MODE_NONE 6'h00
`define CCR_MODE_SDR 6'h01
`define CCR_MODE_DDR 6'h02
`define CCR_MODE_2W 6'h04
`define CCR_MODE_1W 6'h08
`define CCR_MODE_HALF_W 6'h10
`define CCR_MODE_2W_16 6'h20
`endif

// >>> ccr_mode_decode.v
// decoder of lane mapping and interface select codes to one-hot modes
`timescale 1ns/1ns
`include "ccr_defines.vh"
module ccr_mode_decode (
   input wire [2:0] map_code,
   input wire [2:0] sel_code,
   input wire use_sel,
   output reg [5:0] mode_onehot,
   output wire code_valid
);
   // ==========================================
   // decode
   always @* begin
      mode_onehot = `CCR_MODE_NONE;
      if (use_sel) begin
         case (sel_code)
            `CCR_SEL_SDR: mode_onehot = `CCR_MODE_SDR;
            `CCR_SEL_DDR: mode_onehot = `CCR_MODE_DDR;
            `CCR_SEL_2W: mode_onehot = `CCR_MODE_2W;
            `CCR_SEL_1W: mode_onehot = `CCR_MODE_1W;
            `CCR_SEL_HALF_W: mode_onehot = `CCR_MODE_HALF_W;
            default: mode_onehot = `CCR_MODE_NONE;
         endcase
      end else begin
         case (map_code)
            `CCR_MAP_2W_18_14: mode_onehot = `CCR_MODE_2W;
            `CCR_MAP_2W_16: mode_onehot = `CCR_MODE_2W_16;
            `CCR_MAP_1W: mode_onehot = `CCR_MODE_1W;
            `CCR_MAP_HALF_W: mode_onehot = `CCR_MODE_HALF_W;
            `CCR_MAP_DDR: mode_onehot = `CCR_MODE_DDR;
            `CCR_MAP_SDR: mode_onehot = `CCR_MODE_SDR;
            default: mode_onehot = `CCR_MODE_NONE;
         endcase
      end
   end
   assign code_valid = (mode_onehot != `CCR_MODE_NONE);
endmodule // ccr_mode_decode

// >>> ccr_config_regs_properties.sv
// checker of the configuration register bank
`timescale 1ns/1ns
module ccr_config_regs_properties (
   input wire core_clk,
   input wire resetn,
   input wire wr_en,
   input wire rd_en,
   input wire [11:0] addr,
   input wire [7:0] wr_data,
   input wire [7:0] rd_data,
   input wire [5:0] iface_mode,
   input wire iface_mode_valid,
   input wire clock_buffer_powerdown,
   input wire ref_amp_powerdown,
   input wire channel_powerdown,
   input wire full_powerdown
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);
   wire [3:0] pd = {clock_buffer_powerdown, ref_amp_powerdown,
      channel_powerdown, full_powerdown};
   wire wpd = wr_en && addr == 12'h008;
   wire fl = wr_en && addr == 12'h013 && wr_data[0];
   wire sr = wr_en && addr == 12'h000 && wr_data[0];
   // ====================
   // properties
   mode_valid_a: assert property (iface_mode_valid == |iface_mode)
      else $error("valid flag wrong");
   mode_onehot_a: assert property ($onehot0(iface_mode))
      else $error("mode not one-hot");
   pd_write_a: assert property (wpd && !$past(sr) |=> pd[3:1] ==
      {$past(wr_data[5:4]), $past(wr_data[2])}) else $error("pd bits");
   full_pd_a: assert property (wpd && !$past(sr) |=>
      pd[0] == $past(wr_data[0])) else $error("full pd bit");
   fuse_clear_a: assert property (fl |=> pd == 4'h0)
      else $error("fuse load kept pd");
   soft_clear_a: assert property (sr ##2 !wr_en |=> pd == 4'h0)
      else $error("soft reset kept pd");
   pd_fixed_a: assert property (rd_en && addr == 12'h008 |=>
      (rd_data & 8'hCA) == 8'h02) else $error("pd fixed bits");
   ovr_ddr_a: assert property (wr_en && addr == 12'h007 &&
      wr_data[3:0] == 4'h9 && !$past(sr) |-> ##2 iface_mode == 6'h02)
      else $error("ovr");
   cover property (fl);
   cover property (sr);
   cover property (iface_mode == 6'h10);
endmodule // ccr_config_regs_properties
bind ccr_config_regs ccr_config_regs_properties ccr_props_inst (.*);

// >>> ccr_ctrl_model.sv
// controller model driving the register strobes
`timescale 1ns/1ns
module ccr_ctrl_model (
   input wire core_clk,
   output reg wr_en = 1'b0,
   output reg rd_en = 1'b0,
   output reg [11:0] addr = 12'h000,
   output reg [7:0] wr_data = 8'h00
);
   // one-cycle strobe, then scrambled bus
   task xfer(input w, input [11:0] a, input [7:0] d);
      begin
         @(posedge core_clk);
         wr_en <= w;
         rd_en <= !w;
         addr <= a;
         wr_data <= d;
         @(posedge core_clk);
         wr_en <= 1'b0;
         rd_en <= 1'b0;
         addr <= ~a;
         wr_data <= ~d;
      end
   endtask
endmodule // ccr_ctrl_model

// >>> ccr_config_regs_tb_top.sv
// testbench of the configuration register bank
`timescale 1ns/1ns
module ccr_config_regs_tb_top;
   localparam [63:0] SELT = 64'h0000_1008_0400_0201;
   localparam [63:0] MAPT = 64'h0001_0210_0820_0401;
   reg core_clk = 1'b0;
   reg resetn = 1'b0;
   reg pend = 1'b0;
   wire wr_en, rd_en;
   wire [11:0] addr;
   wire [7:0] wr_data, rd_data;
   wire [5:0] iface_mode;
   integer num_errors = 0, checked = 0, i;
   reg [7:0] d;
   reg [13:0] e;
   reg [13:0] q[$];
   initial forever #4 core_clk = ~core_clk;
   ccr_ctrl_model ccr_ctrl_model_inst (.*);
   ccr_config_regs ccr_config_regs_inst (.*, .iface_mode_valid(),
      .clock_buffer_powerdown(), .ref_amp_powerdown(),
      .channel_powerdown(), .full_powerdown());
   task rd(input [11:0] a, input [7:0] x, input [5:0] m);
      begin
         q.push_back({x, m});
         ccr_ctrl_model_inst.xfer(1'b0, a, 8'h00);
      end
   endtask
   task wr(input [11:0] a, input [7:0] x);
      ccr_ctrl_model_inst.xfer(1'b1, a, x);
   endtask
   task close_out;
      begin
         $display("errors %0d checks %0d", num_errors, checked);
         if (num_errors == 0 && checked > 0) $display("RESULT: PASS");
         else $display("RESULT: FAIL");
         $finish;
      end
   endtask
   always @(posedge core_clk) begin
      if (pend) begin
         e = q.pop_front();
         checked = checked + 1;
         if ({rd_data, iface_mode} !== e) begin
            num_errors = num_errors + 1;
            $display("unexpected at %0t: got %h", $time, rd_data);
         end
      end
      pend <= rd_en;
   end
   initial begin
      #20000;
      num_errors = num_errors + 1;
      close_out;
   end
   // ====================
   // tests
   initial begin
      d = $urandom(32'h260C0711);
      repeat (8) @(posedge core_clk);
      resetn <= 1'b1;
      rd(12'h007, 8'h00, 6'h01);
      for (i = 0; i < 6; i = i + 1) begin
         d = $urandom & 8'h35;
         wr(12'h008, d | 8'h02);
         rd(12'h008, d | 8'h02, 6'h01);
      end
      wr(12'h008, 8'h37);
      wr(12'h000, 8'h01);
      repeat (2) @(posedge core_clk);
      rd(12'h008, 8'h02, 6'h01);
      rd(12'h000, 8'h00, 6'h01);
      for (i = 0; i < 8; i = i + 1) begin
         wr(12'h007, 8'h08 | i[7:0]);
         rd(12'h007, 8'h08 | i[7:0], SELT[i*8+:6]);
      end
      wr(12'h007, 8'h05);
      rd(12'h007, 8'h05, 6'h01);
      for (i = 1; i < 7; i = i + 1) begin
         d = {i[2:0], 5'h00};
         wr(12'h007, d);
         rd(12'h007, d, MAPT[(i-1)*8+:6]);
         wr(12'h013, 8'h01);
         rd(12'h007, 8'h00, MAPT[i*8+:6]);
      end
      repeat (2) @(posedge core_clk);
      close_out;
   end
endmodule // ccr_config_regs_tb_top
